// ---- shared/ser_pkg.sv ----
// serializer package: register map, field layout, timing constants
package ser_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int unsigned LANES       = 16;
	localparam int unsigned DIV_STAGES  = 4;
	localparam int unsigned CLK_PERIOD_NS = 10;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W      = 4;
	localparam logic [3:0]  ADDR_CTRL   = 4'h0;
	localparam logic [3:0]  ADDR_STATUS = 4'h4;
	localparam logic [3:0]  ADDR_WORD   = 4'h8;

	// control field positions
	localparam int unsigned CTRL_ORDER_BIT  = 0;
	localparam int unsigned CTRL_FWDOFF_BIT = 1;
	localparam int unsigned CTRL_PHLO_BIT   = 2;
	localparam int unsigned CTRL_PHHI_BIT   = 3;

	// status field positions
	localparam int unsigned STAT_CNT_LSB   = 0;
	localparam int unsigned STAT_WCLK_BIT  = 4;
	localparam int unsigned STAT_WORD_LSB  = 16;

	// reset values: lane zero first, forwarded clock on, 270 degrees
	localparam logic [3:0]  CTRL_RESET  = 4'h0;

	// one quarter of a word period in bit clocks
	localparam logic [3:0]  PHASE_STEP  = 4'h4;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic phase_select_hi;
		logic phase_select_lo;
		logic fwd_clock_off;
		logic bit_order;
	} ser_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [31:0]       writedata;
		logic [3:0]        byteenable;
	} ser_bus_req_t;

endpackage

// ---- src/ser_serializer.sv ----
// 16-to-1 serializer core with divider chain, phase select and Avalon-MM control
//
// Operation
// - sixteen word-rate lanes merge into one full-rate serial stream.
// - word clock comes from four cascaded divide-by-two stages off the bit clock.
// - each divided clock feeds the next stage and one mux tree select level.
// - whole input word captured at the falling edge of the word clock.
// - capture-to-serial-output latency is about one word clock period.
// - order 0 sends lane zero first; order 1 sends lane fifteen first.
// - forwarded-clock disable 0 outputs the bit clock; 1 switches it off.
// - phase selects give 270, 180, 90, 0 degrees for 00, 01, 10, 11.
// - bit clock is forwarded alongside the serial data.
// - phased word clock is driven out for the upstream source.
// - works at any bit clock rate down to static, no minimum.
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module ser_serializer
	import ser_pkg::*;
#(
	parameter int unsigned N_LANES = 16
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       nrst,
	// avalon-mm slave
	input  wire logic [ser_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	// parallel lanes from upstream
	input  wire logic [N_LANES-1:0]         lane_in,
	// outputs
	output logic                            serial_out,
	output logic                            fwd_clock_out,
	output logic                            word_clock_out
);
	import ser_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] lane_of(input logic [3:0] c, input logic order);
		lane_of = order ? (4'hF - c) : c;
	endfunction

	function automatic logic [3:0] phase_lag(input logic hi, input logic lo);
		logic [1:0] sel;
		sel = {hi, lo};
		phase_lag = 4'(PHASE_STEP * (2'h3 - sel));
	endfunction

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	ser_bus_req_t       req;
	ser_ctrl_t          ctrl;
	logic               ack;
	logic [3:0]         div;
	logic [N_LANES-1:0] lane_s1;
	logic [N_LANES-1:0] lane_s2;
	logic [N_LANES-1:0] word_reg;
	logic               word_clock;
	logic               word_fall;
	logic               fwd_on;
	logic [3:0]         next_lag_cnt;
	logic [31:0]        next_readdata;

	assign req = '{address: avs_address, read: avs_read, write: avs_write,
	               writedata: avs_writedata, byteenable: avs_byteenable};

	// ------------------------------------------------------------
	// bus slave: every access answers one cycle after it rises
	// ------------------------------------------------------------
	assign avs_waitrequest = (req.read | req.write) & ~ack;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack <= 1'b0;
		end else begin
			ack <= (req.read | req.write) & ~ack;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl <= ser_ctrl_t'(CTRL_RESET);
		end else if (req.write && ack && req.address == ADDR_CTRL && req.byteenable[0]) begin
			ctrl.bit_order       <= req.writedata[CTRL_ORDER_BIT];
			ctrl.fwd_clock_off   <= req.writedata[CTRL_FWDOFF_BIT];
			ctrl.phase_select_lo <= req.writedata[CTRL_PHLO_BIT];
			ctrl.phase_select_hi <= req.writedata[CTRL_PHHI_BIT];
		end
	end

	always_comb begin
		next_readdata = 32'h0000_0000;
		case (req.address)
			ADDR_CTRL: begin
				next_readdata[CTRL_ORDER_BIT]  = ctrl.bit_order;
				next_readdata[CTRL_FWDOFF_BIT] = ctrl.fwd_clock_off;
				next_readdata[CTRL_PHLO_BIT]   = ctrl.phase_select_lo;
				next_readdata[CTRL_PHHI_BIT]   = ctrl.phase_select_hi;
			end
			ADDR_STATUS: begin
				next_readdata[STAT_CNT_LSB +: 4]        = div;
				next_readdata[STAT_WCLK_BIT]            = word_clock_out;
				next_readdata[STAT_WORD_LSB +: N_LANES] = word_reg;
			end
			ADDR_WORD: begin
				next_readdata[N_LANES-1:0] = word_reg;
			end
			default: begin
				next_readdata = 32'h0000_0000;
			end
		endcase
	end

	// readdata settles on the waiting cycle so it stands at the release edge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (req.read && !ack) begin
			avs_readdata <= next_readdata;
		end
	end

	// ------------------------------------------------------------
	// divider chain
	// ------------------------------------------------------------
	// synchronous cascade: a stage flips when every faster stage is about to
	// fall, i.e. on the falling edge of its neighbour, without ripple skew;
	// pure logic on clk, so it holds state at any rate down to a stopped clock
	genvar gi;
	generate
		for (gi = 0; gi < DIV_STAGES; gi++) begin : g_div
			// stage zero has no faster neighbour, so it toggles on every edge
			if (gi == 0) begin : g_first
				always_ff @(posedge clk) begin
					if (!nrst) begin
						div[gi] <= 1'b0;
					end else begin
						div[gi] <= ~div[gi];
					end
				end
			end else begin : g_next
				always_ff @(posedge clk) begin
					if (!nrst) begin
						div[gi] <= 1'b0;
					end else begin
						div[gi] <= div[gi] ^ (&div[gi-1:0]);
					end
				end
			end
		end
	endgenerate

	// power-up phase only pinned by reset; no alignment to any external event
	assign word_clock = div[DIV_STAGES-1];
	assign word_fall  = &div;

	// ------------------------------------------------------------
	// lane capture
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			lane_s1 <= '0;
			lane_s2 <= '0;
		end else begin
			lane_s1 <= lane_in;
			lane_s2 <= lane_s1;
		end
	end

	// upstream must hold each word a full period; faster lanes alias
	always_ff @(posedge clk) begin
		if (!nrst) begin
			word_reg <= '0;
		end else if (word_fall) begin
			word_reg <= lane_s2;
		end
	end

	// ------------------------------------------------------------
	// mux tree: divider bits are the select levels
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			serial_out <= 1'b0;
		end else begin
			serial_out <= word_reg[lane_of(div, ctrl.bit_order)];
		end
	end

	// ------------------------------------------------------------
	// clock outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fwd_on <= 1'b0;
		end else begin
			fwd_on <= ~ctrl.fwd_clock_off;
		end
	end

	// gating is a model of the buffer enable; an enable change clips one pulse
	assign fwd_clock_out = clk & fwd_on;

	assign next_lag_cnt = div - phase_lag(ctrl.phase_select_hi, ctrl.phase_select_lo);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			word_clock_out <= 1'b0;
		end else begin
			word_clock_out <= next_lag_cnt[3];
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_div_counts_up:
		assert property (nrst |=> div == 4'($past(div) + 4'h1))
		else $error("divider chain did not advance by one");

	a_word_clock_period:
		assert property ($fell(word_clock) |-> ##16 $fell(word_clock))
		else $error("word clock period is not sixteen bit clocks");

	a_capture_on_fall:
		assert property ((div == 4'h0) |-> word_reg == $past(lane_s2))
		else $error("word not captured at word clock fall");

	a_order_lane_zero:
		assert property ((div == 4'h0 && !ctrl.bit_order) |=> serial_out == $past(word_reg[0]))
		else $error("lane zero not sent first");

	a_order_lane_fifteen:
		assert property ((div == 4'h0 && ctrl.bit_order) |=> serial_out == $past(word_reg[15]))
		else $error("lane fifteen not sent first");

	a_word_latency:
		// last lane of a captured word leaves sixteen edges after the capture edge and is sampled at the seventeenth
		assert property ((div == 4'hF && !ctrl.bit_order) |->
		                 ##17 ($past(ctrl.bit_order) ||
		                       serial_out == $past(lane_s2[15], 17)))
		else $error("captured word not out one word period later");

	a_last_bit_latency:
		assert property ((div == 4'hF && !ctrl.bit_order) ##1 !ctrl.bit_order |->
		                 serial_out == $past(word_reg[15]) ##1
		                 serial_out == $past(word_reg[0]))
		else $error("word boundary bits out of place");

	a_fwd_clock_off:
		assert property ($rose(ctrl.fwd_clock_off) |=> !fwd_on ##0 !fwd_clock_out)
		else $error("forwarded clock not switched off");

	a_phase_zero:
		assert property ((ctrl.phase_select_hi && ctrl.phase_select_lo)[*2]
		                 |-> word_clock_out == $past(word_clock))
		else $error("0 degree phase wrong");

	a_phase_ninety:
		assert property ((ctrl.phase_select_hi && !ctrl.phase_select_lo)[*6]
		                 |-> word_clock_out == $past(word_clock, 5))
		else $error("90 degree phase wrong");

	a_phase_one_eighty:
		assert property ((!ctrl.phase_select_hi && ctrl.phase_select_lo)[*2]
		                 |-> word_clock_out == !$past(word_clock))
		else $error("180 degree phase wrong");

	// both low follows reset, so the $past window must not reach into it
	a_phase_two_seventy:
		assert property ((nrst && !ctrl.phase_select_hi && !ctrl.phase_select_lo)[*6]
		                 |-> word_clock_out == !$past(word_clock, 5))
		else $error("270 degree phase wrong");

	a_fwd_clock_on:
		assert property ((nrst && !ctrl.fwd_clock_off)[*2] |-> fwd_on)
		else $error("forwarded clock not running");

	a_ctrl_write_lands:
		assert property ((req.write && !avs_waitrequest && req.address == ADDR_CTRL &&
		                  req.byteenable[0])
		                 |=> ctrl == ser_ctrl_t'($past(req.writedata[3:0])))
		else $error("control write did not land");

	a_bus_one_wait:
		assert property (((req.read || req.write) && avs_waitrequest) |=> !avs_waitrequest)
		else $error("bus access waited more than one cycle");

	c_order_swap:  cover property (ctrl.bit_order && div == 4'h0);
	c_fwd_off:     cover property (ctrl.fwd_clock_off && !fwd_on);
	c_phase_180:   cover property (!ctrl.phase_select_hi && ctrl.phase_select_lo && word_fall);
	c_status_read: cover property (req.read && ack && req.address == ADDR_STATUS);
	c_phase_90:    cover property (ctrl.phase_select_hi && !ctrl.phase_select_lo && word_fall);

endmodule

// ---- test/ser_upstream.sv ----
// upstream word source model feeding the parallel lanes
`timescale 1ns/1ps
module ser_upstream (
	// clock and timing reference
	input  wire logic        clk,
	input  wire logic        word_clock_out,
	// word the bench wants sent
	input  wire logic [15:0] word_in,
	// lanes toward the serializer
	output logic      [15:0] lane_in
);
	logic prev_wclk;
	// new word just after the word clock rises; clear of the capture edge except at 90 degrees, where lane_s2 changes on it
	initial begin
		lane_in = 16'h0000;
		prev_wclk = 1'b0;
		forever begin
			@(posedge clk);
			prev_wclk <= word_clock_out;
			if (word_clock_out && !prev_wclk) begin
				lane_in <= word_in;
			end
		end
	end
endmodule

// ---- test/serializer_16_to_1_bench.sv ----
// self-checking bench for the serializer core
`timescale 1ns/1ps
module serializer_16_to_1_bench;
	import ser_pkg::*;
	typedef struct packed {
		logic [3:0]  ctrl;
		logic [15:0] word;
		logic [15:0] exp;
	} ser_row_t;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [15:0] word_in = 16'h0000;
	logic [15:0] lane_in;
	logic        serial_out;
	logic        fwd_clock_out;
	logic        word_clock_out;
	int          err_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          t0;
	int          t1;
	int          t2;
	logic [31:0] rd;
	logic [15:0] got;
	// first bit sent sits in the top bit of exp
	ser_row_t rows [6] = '{
		'{4'hC, 16'h0001, 16'h8000}, '{4'hD, 16'h0001, 16'h0001},
		'{4'hC, 16'hA5C3, 16'hC3A5}, '{4'hD, 16'hA5C3, 16'hA5C3},
		'{4'hE, 16'hFFFF, 16'hFFFF}, '{4'hF, 16'h8000, 16'h8000}};

	always #5 clk = ~clk;
	always @(posedge clk) cyc++;

	ser_serializer #(.N_LANES(16)) i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .lane_in(lane_in), .serial_out(serial_out),
		.fwd_clock_out(fwd_clock_out), .word_clock_out(word_clock_out));
	ser_upstream i_src (.clk(clk), .word_clock_out(word_clock_out), .word_in(word_in),
		.lane_in(lane_in));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// one transfer; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// waits for the word clock to fall, then gathers sixteen serial bits
	task automatic grab(output logic [15:0] w, output int t);
		logic prev;
		int n;
		n = 0;
		// level just after the last edge, so a fall at the next edge is seen
		#1;
		prev = word_clock_out;
		@(posedge clk);
		#1;
		while (!(prev === 1'b1 && word_clock_out === 1'b0) && n < 40) begin
			prev = word_clock_out;
			n++;
			@(posedge clk);
			#1;
		end
		t = cyc;
		w = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			w = {w[14:0], serial_out};
			if (i < 15) begin
				@(posedge clk);
				#1;
			end
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b0, ADDR_CTRL, 32'h0, 4'hF);
		chk(rd, 32'h0);
		foreach (rows[i]) begin
			bus(1'b1, ADDR_CTRL, {28'h0, rows[i].ctrl}, 4'hF);
			word_in <= rows[i].word;
			repeat (48) @(posedge clk);
			grab(got, t1);
			chk({16'h0, got}, {16'h0, rows[i].exp});
			bus(1'b0, ADDR_WORD, 32'h0, 4'hF);
			chk(rd, {16'h0, rows[i].word});
			@(posedge clk);
			#2;
			chk({31'h0, fwd_clock_out}, {31'h0, ~rows[i].ctrl[1]});
		end
		bus(1'b0, ADDR_STATUS, 32'h0, 4'hF);
		chk({16'h0, rd[31:16]}, {16'h0, rows[5].word});
		$display("row tests done");
		// lag grows by four bit clocks per step down from both selects high
		for (int p = 3; p >= 0; p--) begin
			bus(1'b1, ADDR_CTRL, {28'h0, p[1:0], 2'b00}, 4'hF);
			repeat (32) @(posedge clk);
			grab(got, t1);
			if (p == 3) t0 = t1;
			grab(got, t2);
			chk(32'((t1 - t0 + 64) % 16), 32'(4 * (3 - p)));
			chk(32'(t2 - t1), 32'd16);
		end
		$display("phase tests done");
		bus(1'b1, ADDR_CTRL, 32'hF, 4'h0);
		bus(1'b1, ADDR_WORD, 32'hFFFF, 4'hF);
		bus(1'b0, 4'hC, 32'h0, 4'hF);
		chk(rd, 32'h0);
		bus(1'b0, ADDR_CTRL, 32'h0, 4'hF);
		chk(rd, 32'h0);
		nrst <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b0, ADDR_CTRL, 32'h0, 4'hF);
		chk(rd, 32'h0);
		@(posedge clk);
		#2;
		chk({31'h0, fwd_clock_out}, 32'h1);
		$display("reset tests done");
		tally_and_finish();
	end

	initial begin
		#50000;
		err_count++;
		tally_and_finish();
	end
endmodule
